// ===== sdf_ctrl_model.sv
/* pulse generator model of the motion controller.
   tb calls pulse at a falling edge of CLOCK. */
`timescale 1ns/1ps
module sdf_ctrl_model (
  input wire logic CLOCK,
  output logic     strobe,
  output logic     direction);
  initial strobe = 0;
  initial direction = 0;
  task automatic pulse(input logic d, input int hi);
    repeat (500) @(negedge CLOCK);
    direction = d;
    repeat (500) @(negedge CLOCK);
    strobe = 1;
    repeat (hi) @(negedge CLOCK);
    strobe = 0;
    repeat (250) @(negedge CLOCK);
  endtask
endmodule

// ===== sdf_pkg.sv
/*
  shared constants and carrier types of the step/direction input and fault latch block.
  assumes a single 100 MHz system clock.
*/
package sdf_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ          = 100_000_000;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int STROBE_MIN_NS   = 2500;
  // least time rounds up to whole cycles
  localparam int STROBE_MIN_CYC  = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IDLE_TIME_MS    = 1000;
  localparam int IDLE_CYC        = (CLK_HZ / 1000) * IDLE_TIME_MS;
  localparam int POS_W           = 32;
  localparam int CUR_W           = 3;
  localparam logic [1:0] CUR_FULL = 2'h1;
  localparam logic [1:0] CUR_HALF = 2'h2;

  typedef struct packed {
    logic over_voltage;
    logic over_current;
    logic short_circuit;
  } sdf_fault_t;

  typedef enum logic [1:0] {
    SDF_RUN   = 2'b01,
    SDF_FAULT = 2'b10
  } sdf_state_t;
endpackage

// ===== sdf_pulse_filter.sv
/*
  step strobe qualifier: a high level held for a minimum number of cycles yields one
  effective step pulse. assumes the strobe input is synchronous to the clock.
*/
`timescale 1ns/1ps
module sdf_pulse_filter #(
  parameter int MIN_CYC = 250
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic strobe,
  output logic      step
);
  import sdf_pkg::*;

  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic        fired_reg;
  wire  logic  at_min = (cnt_reg == 16'(MIN_CYC - 1));

  // short pulses never reach the minimum and are dropped
  assign cnt_next = strobe ? (at_min ? cnt_reg : cnt_reg + 16'h1) : 16'h0; // R3
  assign step     = strobe && at_min && !fired_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg   <= 16'h0;
      fired_reg <= 1'b0;
    end else begin
      cnt_reg   <= cnt_next;
      fired_reg <= strobe && (fired_reg || at_min); // R4
    end
  end
endmodule

// ===== sdf_step_dir_fault.sv
/*
  step/direction input sequencing with latched protection fault of a stepper drive:
  qualifies step strobes, tracks the microstep position, reduces standstill current
  and latches the first and any later protection causes until power-on reset.
  assumes controller inputs synchronous to CLOCK and SYS_RST as power-on reset only.
  assumes each FAULT_IN bit is an already filtered level from the analog sensing.
  assumes an open permit line reads as low at this input.
*/
// How it works
// R1: the controller settles the permit line 5 us before changing direction.
// R2: the controller holds direction stable 5 us before each effective step edge.
// R3: a step pulse shorter than 2.5 us may be ignored by the drive.
// R4: the step line stays low at least 2.5 us between pulses.
// R5: over-voltage enters the fault state and turns the indicator red.
// R6: continuous over-current enters the fault state.
// R7: a coil-to-coil or coil-to-ground short enters the fault state.
// R8: during a fault the motor is de-energised and the indicator is red.
// R9: the fault stays latched until power-on reset.
// R10: one second after the last step the current drops to half unless full standstill is set.
// R11: an inactive or open permit line keeps the drive enabled; active disables outputs.
// R12: each effective step moves the microstep position by one in the sampled direction.
`timescale 1ns/1ps
module sdf_step_dir_fault #(
  parameter int IDLE_CYCLES = sdf_pkg::IDLE_CYC
) (
  input  wire logic                     CLOCK,
  input  wire logic                     SYS_RST,
  input  wire logic                     STEP_STROBE,
  input  wire logic                     DIRECTION,
  input  wire logic                     OUTPUT_PERMIT,
  input  wire logic                     STANDSTILL_FULL,
  input  wire sdf_pkg::sdf_fault_t      FAULT_IN,
  output logic                          POWER_STAGE_ON,
  output logic                          LED_RED,
  output logic                          LED_GREEN,
  output logic [1:0]                    CURRENT_SCALE,
  output logic [sdf_pkg::POS_W-1:0]     MICROSTEP_POS,
  output logic                          STEP_TAKEN,
  output sdf_pkg::sdf_fault_t           FAULT_CAUSE
);
  import sdf_pkg::*;

  // ----------------------------------------
  // state decode
  // ----------------------------------------
  // full-code compare, shared by the indicator and enable paths
  function automatic logic in_state(
    input sdf_state_t cur,
    input sdf_state_t want
  );
    in_state = (cur == want);
  endfunction

  // ----------------------------------------
  // step qualification
  // ----------------------------------------
  logic step;

  sdf_pulse_filter #(
    .MIN_CYC (STROBE_MIN_CYC)
  ) u_filter (
    .clk    (CLOCK),
    .rst    (SYS_RST),
    .strobe (STEP_STROBE),
    .step   (step)
  );

  // ----------------------------------------
  // fault inputs
  // ----------------------------------------
  localparam int FAULT_W = $bits(sdf_fault_t);

  // any one cause is enough; they are not ranked
  wire logic [FAULT_W-1:0] fault_bits = FAULT_IN;
  wire logic               fault_hit  = FAULT_IN.over_voltage   // R5
                                      | FAULT_IN.over_current   // R6
                                      | FAULT_IN.short_circuit; // R7

  // ----------------------------------------
  // fault latch
  // ----------------------------------------
  sdf_state_t state_reg;
  sdf_state_t state_next;

  always_comb begin
    unique case (state_reg)
      SDF_RUN: begin
        if (fault_hit) begin
          state_next = SDF_FAULT; // R5 R6 R7
        end else begin
          state_next = SDF_RUN;
        end
      end
      SDF_FAULT: begin
        // no way back out short of power-on reset
        state_next = SDF_FAULT; // R9
      end
      default: begin
        // an upset code falls to the safe side
        state_next = SDF_FAULT;
      end
    endcase
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg <= SDF_RUN;
    end else begin
      state_reg <= state_next; // R9
    end
  end

  wire logic run_now   = in_state(state_reg, SDF_RUN);
  wire logic fault_now = in_state(state_reg, SDF_FAULT);

  // ----------------------------------------
  // fault cause record
  // ----------------------------------------
  wire logic [FAULT_W-1:0] cause_bits;

  // each cause has its own sticky latch, so causes seen later still show
  for (genvar b = 0; b < FAULT_W; b++) begin : g_cause
    logic      seen_reg;
    wire logic seen_next = seen_reg | fault_bits[b]; // R9

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
        seen_reg <= 1'b0;
      end else begin
        seen_reg <= seen_next;
      end
    end

    assign cause_bits[b] = seen_reg;
  end

  // ----------------------------------------
  // permit and enable
  // ----------------------------------------
  wire logic enabled = !OUTPUT_PERMIT && run_now; // R11
  wire logic advance = step && enabled;           // R8 R11

  // ----------------------------------------
  // position
  // ----------------------------------------
  logic             taken_reg;
  logic [POS_W-1:0] pos_reg;

  wire logic             taken_next = advance;
  // direction is read at the same edge that takes the step
  wire logic [POS_W-1:0] pos_step   = DIRECTION ? pos_reg + POS_W'(1)
                                                : pos_reg - POS_W'(1); // R12
  // refused steps leave the position alone
  wire logic [POS_W-1:0] pos_next   = advance ? pos_step : pos_reg;     // R12

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pos_reg <= '0;
    end else begin
      pos_reg <= pos_next;
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      taken_reg <= 1'b0;
    end else begin
      taken_reg <= taken_next;
    end
  end

  // ----------------------------------------
  // idle timer
  // ----------------------------------------
  logic [31:0] idle_reg;

  wire logic        idle_done  = (idle_reg >= 32'(IDLE_CYCLES));
  wire logic [31:0] idle_count = idle_done ? idle_reg : idle_reg + 32'h1;
  // refused steps restart the timer too, the controller is still commanding
  wire logic [31:0] idle_next  = step ? 32'h0 : idle_count;

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      idle_reg <= 32'h0;
    end else begin
      idle_reg <= idle_next;
    end
  end

  // ----------------------------------------
  // standstill current
  // ----------------------------------------
  logic [1:0] scale_reg;

  // full standstill current overrides the timer
  wire logic       go_half    = idle_done && !STANDSTILL_FULL; // R10
  wire logic [1:0] scale_next = go_half ? CUR_HALF : CUR_FULL; // R10

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      scale_reg <= CUR_FULL;
    end else begin
      scale_reg <= scale_next;
    end
  end

  // ----------------------------------------
  // indicators
  // ----------------------------------------
  assign LED_RED     = fault_now; // R5 R8
  assign LED_GREEN   = run_now;
  assign FAULT_CAUSE = cause_bits;

  // ----------------------------------------
  // drive outputs
  // ----------------------------------------
  // the power stage follows the permit line at once, not a cycle late
  assign POWER_STAGE_ON = enabled; // R8 R11
  assign CURRENT_SCALE  = scale_reg;
  assign MICROSTEP_POS  = pos_reg;
  assign STEP_TAKEN     = taken_reg;
endmodule

// ===== sdf_step_dir_fault_sva.sv
/* port assertions of the step/direction fault block.
   bound to the top module from tb. */
`timescale 1ns/1ps
module sdf_chk
  import sdf_pkg::*;
#(
  parameter int IDLE_CYCLES = IDLE_CYC
) (
  input wire logic             CLOCK,
  input wire logic             SYS_RST,
  input wire logic             DIRECTION,
  input wire logic             OUTPUT_PERMIT,
  input wire logic             STANDSTILL_FULL,
  input wire sdf_fault_t       FAULT_IN,
  input wire sdf_fault_t       FAULT_CAUSE,
  input wire logic             POWER_STAGE_ON,
  input wire logic             LED_RED,
  input wire logic             LED_GREEN,
  input wire logic             STEP_TAKEN,
  input wire logic [1:0]       CURRENT_SCALE,
  input wire logic [POS_W-1:0] MICROSTEP_POS
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  a_volt_red: assert property (FAULT_IN.over_voltage |=> LED_RED && !LED_GREEN)
    else $error("no red");
  a_amp_cause: assert property (FAULT_IN.over_current |=> FAULT_CAUSE.over_current)
    else $error("no cause");
  a_short_off: assert property (FAULT_IN.short_circuit |=> !POWER_STAGE_ON)
    else $error("stage on");
  a_fault_free: assert property (LED_RED |-> !POWER_STAGE_ON)
    else $error("stage on");
  a_fault_kept: assert property (LED_RED |=> LED_RED [*2])
    else $error("fault lost");
  a_step_full: assert property (STEP_TAKEN |=> CURRENT_SCALE == CUR_FULL)
    else $error("no full");
  a_half_gate: assert property ($rose(CURRENT_SCALE == CUR_HALF) |-> !$past(STANDSTILL_FULL))
    else $error("bad half");
  a_permit_off: assert property (OUTPUT_PERMIT |-> !POWER_STAGE_ON)
    else $error("stage on");
  a_step_move: assert property (STEP_TAKEN |-> !$past(OUTPUT_PERMIT) &&
    MICROSTEP_POS == $past(MICROSTEP_POS) + ($past(DIRECTION) ? 32'h1 : '1))
    else $error("bad step");
endmodule

// ===== tb.sv
/* self-checking bench of the step/direction fault block.
   needs the package, controller model and checker. */
`timescale 1ns/1ps
module tb;
  import sdf_pkg::*;
  logic CLOCK = 0, SYS_RST = 1, permit = 0, full = 0, stb, dir, pse, red, grn, tkn;
  sdf_fault_t fin = '0, cause;
  logic [1:0] scl;
  logic [POS_W-1:0] pos;
  int fail_count = 0, n_checks = 0, cyc = 0, n_taken = 0;
  initial forever #5 CLOCK = ~CLOCK;
  sdf_ctrl_model i_sdf_ctrl_model(.CLOCK, .strobe(stb), .direction(dir));
  sdf_step_dir_fault #(.IDLE_CYCLES(100)) i_sdf_step_dir_fault(.CLOCK, .SYS_RST,
    .STEP_STROBE(stb), .DIRECTION(dir), .OUTPUT_PERMIT(permit), .STANDSTILL_FULL(full),
    .FAULT_IN(fin), .POWER_STAGE_ON(pse), .LED_RED(red), .LED_GREEN(grn),
    .CURRENT_SCALE(scl), .MICROSTEP_POS(pos), .STEP_TAKEN(tkn), .FAULT_CAUSE(cause));
  always @(negedge CLOCK) if (tkn === 1'b1) n_taken++;
  task automatic chk(input logic [63:0] s, e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d fails=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic pul(input logic d, input int h);
    i_sdf_ctrl_model.pulse(d, h);
  endtask
  task automatic rst;
    SYS_RST = 1;
    repeat (4) @(negedge CLOCK);
    SYS_RST = 0;
  endtask
  task automatic t_steps;
    pul(1, 250);
    pul(1, 250);
    pul(0, 250);
    pul(1, 249);
    chk(pos, 1);
    chk(scl, CUR_HALF);
    full = 1;
    pul(1, 250);
    chk(scl, CUR_FULL);
    permit = 1;
    pul(1, 250);
    chk({pse, pos}, 2);
    chk(n_taken, 4);
    permit = 0;
  endtask
  task automatic t_fault;
    for (int i = 0; i < 3; i++) begin
      rst();
      fin = 3'h1 << i;
      @(negedge CLOCK);
      fin = '0;
      pul(1, 250);
      chk({red, grn, pse, cause, pos}, {3'h4, 3'h1 << i, 32'h0});
    end
    rst();
    chk({red, grn}, 2'h1);
  endtask
  initial begin
    rst();
    t_steps();
    t_fault();
    tally_and_finish();
  end
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      tally_and_finish();
    end
  end
endmodule
bind sdf_step_dir_fault sdf_chk #(.IDLE_CYCLES(IDLE_CYCLES)) i_sdf_chk(
  .CLOCK(CLOCK), .SYS_RST(SYS_RST), .DIRECTION(DIRECTION), .OUTPUT_PERMIT(OUTPUT_PERMIT),
  .STANDSTILL_FULL(STANDSTILL_FULL), .FAULT_IN(FAULT_IN), .FAULT_CAUSE(FAULT_CAUSE),
  .POWER_STAGE_ON(POWER_STAGE_ON), .LED_RED(LED_RED), .LED_GREEN(LED_GREEN),
  .STEP_TAKEN(STEP_TAKEN), .CURRENT_SCALE(CURRENT_SCALE), .MICROSTEP_POS(MICROSTEP_POS));
